// ### common/gp_event_defs.svh
`ifndef GP_EVENT_DEFS_SVH
`define GP_EVENT_DEFS_SVH

// ----------------------------------------------------------------
// configuration space decode
// ----------------------------------------------------------------
`define EVT_CFG_FUNC 3'h0
`define EVT_STATUS_ADDR 8'ha8
`define EVT_ENABLE_ADDR 8'haa
`define EVT_INPUT_ADDR 8'hac
`define EVT_OUTPUT_ADDR 8'hae

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define EVT_WRITABLE_MASK 16'hc91f
`define EVT_PIN_MASK 16'h001f
`define EVT_RESET_VAL 16'h0000
`define EVT_VIDEO0_BIT 15
`define EVT_VIDEO1_BIT 14
`define EVT_POWER_BIT 11
`define EVT_PROGV_BIT 8
`define EVT_PIN_COUNT 5

`endif

// ### common/gp_event_pkg.sv
`include "gp_event_defs.svh"

package gp_event_pkg;

   typedef logic [15:0] cfg_word_t;
   typedef logic [`EVT_PIN_COUNT-1:0] pin_vec_t;

   // which register a configuration access selects
   typedef enum logic [2:0] {
      SEL_NONE   = 3'b000,
      SEL_STATUS = 3'b001,
      SEL_ENABLE = 3'b010,
      SEL_INPUT  = 3'b011,
      SEL_OUTPUT = 3'b100
   } reg_sel_t;

endpackage

// ### common/gp_sync_if.sv
`timescale 1ns/1ps

interface gp_sync_if;
   import gp_event_pkg::*;

   pin_vec_t rawLevel;
   pin_vec_t level;
   pin_vec_t change;

   modport sampler (input rawLevel, output level, output change);
   modport user (output rawLevel, input level, input change);
endinterface

// ### verilog/gp_pin_sync.sv
`timescale 1ns/1ps
`include "gp_event_defs.svh"

module gp_pin_sync
   import gp_event_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin levels in, clean levels and change pulses out
   gp_sync_if.sampler pins
);

   pin_vec_t meta_reg;
   pin_vec_t level_reg;
   pin_vec_t prev_reg;

   // ----------------------------------------------------------------
   // two-flop synchroniser then edge detect, one stage per pin
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `EVT_PIN_COUNT; i = i + 1) begin : g_pin
         // chain follows the pin through reset, so no false edge after it
         always_ff @(posedge clk) begin
            meta_reg[i] <= pins.rawLevel[i];
            level_reg[i] <= meta_reg[i];
            prev_reg[i] <= level_reg[i];
         end
         assign pins.change[i] = ~rst & (level_reg[i] ^ prev_reg[i]);
      end
   endgenerate

   assign pins.level = level_reg;

endmodule

// ### verilog/gp_event_and_io_port.sv
// How it works
// - an enabled, set status bit holds the event output until cleared
// - event output is driven only when a multifunction pin carries it
// - registers answer only function 0 accesses at a8h-afh; address bit 0 is ignored, so abh reaches aah
// - enable bit 15 raises the event on socket 0 video flag change
// - enable bit 14 raises the event on socket 1 video flag change
// - enable bit 11 raises the event on any socket power change
// - enable bit 8 raises the event on programming voltage 12 V change
// - enable bits 4..0 gate pin level changes on pins configured as input
// - enable bits 13-12, 10-9, 7-5 read zero and ignore writes
// - input register bits 4..0 return sampled pin levels
// - upper bits 15..5 of input and output registers read zero
// - output register bits 4..0 drive pins configured as outputs
// - output register reads return last written value, not the pin
// - writing one to a status bit clears it and releases the event
// - status bits set regardless of enable; enable gates only the output
`timescale 1ns/1ps
`include "gp_event_defs.svh"

module gp_event_and_io_port
   import gp_event_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration access
   input wire logic [2:0] cfgFunc,
   input wire logic [7:0] cfgAddr,
   input wire logic cfgRd,
   input wire logic cfgWr,
   input wire logic [1:0] cfgByteEn,
   input wire logic [15:0] cfgWData,
   output logic [15:0] cfgRData,
   output logic cfgRdAck,
   // event sources
   input wire logic zoomedVideoOn0,
   input wire logic zoomedVideoOn1,
   input wire logic powerChange,
   input wire logic progVoltChange,
   // pin function setup
   input wire logic eventPinRouted,
   input wire pin_vec_t pinIsInput,
   input wire pin_vec_t pinIsOutput,
   // multifunction pins 5, 4, 2, 1, 0
   input wire pin_vec_t multiPinIn,
   output pin_vec_t multiPinOut,
   output pin_vec_t multiPinOe,
   // general-purpose event pin
   output logic generalEventN,
   output logic generalEventOe
);

   cfg_word_t eventEnableMask_reg;
   cfg_word_t eventStatus_reg;
   cfg_word_t pinOutputLevels_reg;
   cfg_word_t pinInputLevels;
   cfg_word_t eventStatus_next;
   cfg_word_t setVec;
   cfg_word_t clearVec;
   cfg_word_t byteMask;
   cfg_word_t readMux;
   logic video0Prev_reg;
   logic video1Prev_reg;
   logic eventActive_reg;
   logic hitFunc;
   reg_sel_t sel;

   gp_sync_if syncIf ();

   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   assign syncIf.rawLevel = multiPinIn;

   gp_pin_sync u_sync (
      .clk(clk),
      .rst(rst),
      .pins(syncIf.sampler)
   );

   assign pinInputLevels = {11'h000, syncIf.level};

   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   assign hitFunc = (cfgFunc == `EVT_CFG_FUNC);
   assign byteMask = {{8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};

   always_comb begin
      sel = SEL_NONE;
      if (hitFunc) begin
         if ({cfgAddr[7:1], 1'b0} == `EVT_STATUS_ADDR) begin
            sel = SEL_STATUS;
         end else if ({cfgAddr[7:1], 1'b0} == `EVT_ENABLE_ADDR) begin
            sel = SEL_ENABLE;
         end else if ({cfgAddr[7:1], 1'b0} == `EVT_INPUT_ADDR) begin
            sel = SEL_INPUT;
         end else if ({cfgAddr[7:1], 1'b0} == `EVT_OUTPUT_ADDR) begin
            sel = SEL_OUTPUT;
         end
      end
   end

   // ----------------------------------------------------------------
   // event enable register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         eventEnableMask_reg <= `EVT_RESET_VAL;
      end else if (cfgWr && sel == SEL_ENABLE) begin
         eventEnableMask_reg <= ((cfgWData & byteMask)
            | (eventEnableMask_reg & ~byteMask))
            & `EVT_WRITABLE_MASK;
      end
   end

   // ----------------------------------------------------------------
   // output levels register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pinOutputLevels_reg <= `EVT_RESET_VAL;
      end else if (cfgWr && sel == SEL_OUTPUT) begin
         pinOutputLevels_reg <= ((cfgWData & byteMask)
            | (pinOutputLevels_reg & ~byteMask))
            & `EVT_PIN_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         multiPinOut <= '0;
         multiPinOe <= '0;
      end else begin
         multiPinOut <= pinOutputLevels_reg[`EVT_PIN_COUNT-1:0];
         multiPinOe <= pinIsOutput;
      end
   end

   // ----------------------------------------------------------------
   // event status
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         video0Prev_reg <= 1'b0;
         video1Prev_reg <= 1'b0;
      end else begin
         video0Prev_reg <= zoomedVideoOn0;
         video1Prev_reg <= zoomedVideoOn1;
      end
   end

   always_comb begin
      setVec = '0;
      setVec[`EVT_VIDEO0_BIT] = zoomedVideoOn0 ^ video0Prev_reg;
      setVec[`EVT_VIDEO1_BIT] = zoomedVideoOn1 ^ video1Prev_reg;
      setVec[`EVT_POWER_BIT] = powerChange;
      setVec[`EVT_PROGV_BIT] = progVoltChange;
      setVec[`EVT_PIN_COUNT-1:0] = syncIf.change & pinIsInput;
   end

   assign clearVec = (cfgWr && sel == SEL_STATUS) ?
      (cfgWData & byteMask) : '0;

   // set wins over a clear in the same cycle
   assign eventStatus_next = ((eventStatus_reg & ~clearVec) | setVec)
      & `EVT_WRITABLE_MASK;

   always_ff @(posedge clk) begin
      if (rst) begin
         eventStatus_reg <= `EVT_RESET_VAL;
      end else begin
         eventStatus_reg <= eventStatus_next;
      end
   end

   // ----------------------------------------------------------------
   // event output
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         eventActive_reg <= 1'b0;
      end else begin
         eventActive_reg <= |(eventStatus_reg & eventEnableMask_reg);
      end
   end

   assign generalEventN = ~eventActive_reg;
   assign generalEventOe = eventPinRouted;

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb begin
      unique case (sel)
         SEL_NONE: readMux = '0;
         SEL_STATUS: readMux = eventStatus_reg;
         SEL_ENABLE: readMux = eventEnableMask_reg;
         SEL_INPUT: readMux = pinInputLevels;
         SEL_OUTPUT: readMux = pinOutputLevels_reg;
         default: readMux = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cfgRData <= '0;
         cfgRdAck <= 1'b0;
      end else begin
         cfgRData <= cfgRd ? readMux : '0;
         cfgRdAck <= cfgRd;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_write(logic [7:0] a);
      cfgWr && hitFunc && cfgAddr == a && cfgByteEn == 2'b11;
   endsequence

   sequence s_armed;
      |(eventStatus_reg & eventEnableMask_reg);
   endsequence

   property p_hold;
      s_armed ##0 !(cfgWr && (sel == SEL_STATUS || sel == SEL_ENABLE))
         |=> s_armed ##1 !generalEventN;
   endproperty
   a_hold: assert property (p_hold)
      else $error("event output released while armed");

   property p_route;
      generalEventOe == eventPinRouted;
   endproperty
   a_route: assert property (p_route)
      else $error("event pin drive not tied to routing");

   property p_func;
      cfgWr && !hitFunc |=> $stable(eventEnableMask_reg)
         && $stable(pinOutputLevels_reg);
   endproperty
   a_func: assert property (p_func)
      else $error("register written by another function");

   property p_video0;
      $changed(zoomedVideoOn0) && eventEnableMask_reg[15]
         && !(cfgWr && sel == SEL_ENABLE)
         |=> eventStatus_reg[15] ##1 !generalEventN;
   endproperty
   a_video0: assert property (p_video0)
      else $error("socket 0 video change did not raise event");

   property p_video1;
      $changed(zoomedVideoOn1) |=> eventStatus_reg[14];
   endproperty
   a_video1: assert property (p_video1)
      else $error("socket 1 video change not recorded");

   property p_power;
      powerChange && !eventEnableMask_reg[11] |=> eventStatus_reg[11];
   endproperty
   a_power: assert property (p_power)
      else $error("power change not recorded");

   property p_progv;
      progVoltChange |=> eventStatus_reg[8];
   endproperty
   a_progv: assert property (p_progv)
      else $error("programming voltage change not recorded");

   property p_pin;
      |(syncIf.change & ~pinIsInput) |=> (eventStatus_reg[4:0]
         & ~$past(eventStatus_reg[4:0]) & $past(syncIf.change)
         & ~$past(pinIsInput)) == 5'h00;
   endproperty
   a_pin: assert property (p_pin)
      else $error("pin not set up as input raised status");

   property p_reserved;
      (eventEnableMask_reg & ~`EVT_WRITABLE_MASK) == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved enable bit set");

   property p_inread;
      cfgRd && sel == SEL_INPUT
         |=> cfgRData == {11'h000, $past(syncIf.level)};
   endproperty
   a_inread: assert property (p_inread)
      else $error("input register read mismatch");

   property p_upper;
      cfgRd && (sel == SEL_INPUT || sel == SEL_OUTPUT)
         |=> cfgRData[15:5] == 11'h000;
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper bits not zero");

   property p_drive;
      s_write(`EVT_OUTPUT_ADDR) ##2 1'b1
         |-> multiPinOut == $past(cfgWData[4:0], 2);
   endproperty
   a_drive: assert property (p_drive)
      else $error("pin output not written value");

   property p_outread;
      s_write(`EVT_OUTPUT_ADDR) ##1 !cfgWr ##1 (cfgRd && sel == SEL_OUTPUT)
         |=> cfgRData[4:0] == $past(cfgWData[4:0], 3);
   endproperty
   a_outread: assert property (p_outread)
      else $error("output read not last written value");

   property p_clear;
      s_write(`EVT_STATUS_ADDR) ##0 (cfgWData[11] && !powerChange)
         |=> !eventStatus_reg[11];
   endproperty
   a_clear: assert property (p_clear)
      else $error("write one did not clear status");

   property p_setwins;
      s_write(`EVT_STATUS_ADDR) ##0 progVoltChange |=> eventStatus_reg[8];
   endproperty
   a_setwins: assert property (p_setwins)
      else $error("set lost against clear");

   property p_or;
      s_armed |=> !generalEventN;
   endproperty
   a_or: assert property (p_or)
      else $error("event output not OR of armed bits");

endmodule

// ### test/gp_board_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// board pins and system event line
// ----------------------------------------------------------------
module gp_board_model
   import gp_event_pkg::*;
(
   // from the port
   input wire pin_vec_t multiPinOut,
   input wire pin_vec_t multiPinOe,
   input wire logic generalEventN,
   input wire logic generalEventOe,
   // weak board drive on each pin
   input wire pin_vec_t boardLevel,
   // resolved lines
   output pin_vec_t multiPinIn,
   output logic eventLine
);
   // a driving port pin wins over the board's weak drive
   assign multiPinIn = (multiPinOe & multiPinOut)
      | (~multiPinOe & boardLevel);
   // pulled up while no pin carries the event
   assign eventLine = generalEventOe ? generalEventN : 1'h1;
endmodule

// ### test/gp_event_and_io_port_tb.sv
`timescale 1ns/1ps

module gp_event_and_io_port_tb;
   import gp_event_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [2:0] cfgFunc = 3'h0;
   logic [7:0] cfgAddr = 8'h00;
   logic cfgRd = 1'h0;
   logic cfgWr = 1'h0;
   logic [1:0] cfgByteEn = 2'h3;
   logic [15:0] cfgWData = 16'h0000;
   logic [15:0] cfgRData;
   logic cfgRdAck;
   logic video0 = 1'h0;
   logic video1 = 1'h0;
   logic powerChange = 1'h0;
   logic progVoltChange = 1'h0;
   logic eventPinRouted = 1'h1;
   pin_vec_t pinIsInput = 5'h1f;
   pin_vec_t pinIsOutput = 5'h00;
   pin_vec_t boardLevel = 5'h00;
   pin_vec_t multiPinIn;
   pin_vec_t multiPinOut;
   pin_vec_t multiPinOe;
   logic generalEventN;
   logic generalEventOe;
   logic eventLine;
   int n_errors = 0;
   int comparisons = 0;
   localparam int bitPos[9] = '{15, 14, 11, 8, 4, 3, 2, 1, 0};

   always #12.5 clk = ~clk;

   gp_event_and_io_port uut (.clk(clk), .rst(rst), .cfgFunc(cfgFunc),
      .cfgAddr(cfgAddr), .cfgRd(cfgRd), .cfgWr(cfgWr), .cfgByteEn(cfgByteEn),
      .cfgWData(cfgWData), .cfgRData(cfgRData), .cfgRdAck(cfgRdAck),
      .zoomedVideoOn0(video0), .zoomedVideoOn1(video1),
      .powerChange(powerChange), .progVoltChange(progVoltChange),
      .eventPinRouted(eventPinRouted), .pinIsInput(pinIsInput),
      .pinIsOutput(pinIsOutput), .multiPinIn(multiPinIn),
      .multiPinOut(multiPinOut), .multiPinOe(multiPinOe),
      .generalEventN(generalEventN), .generalEventOe(generalEventOe));

   gp_board_model board (.multiPinOut(multiPinOut), .multiPinOe(multiPinOe),
      .generalEventN(generalEventN), .generalEventOe(generalEventOe),
      .boardLevel(boardLevel), .multiPinIn(multiPinIn),
      .eventLine(eventLine));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d,
      input logic [2:0] f = 3'h0, input logic [1:0] be = 2'h3);
      cfgFunc = f;
      cfgAddr = a;
      cfgWData = d;
      cfgByteEn = be;
      cfgWr = 1'h1;
      cyc(1);
      cfgWr = 1'h0;
      cfgFunc = 3'h0;
      cyc(1);
   endtask

   task automatic rdchk(input string name, input logic [7:0] a,
      input logic [15:0] exp, input logic [2:0] f = 3'h0);
      cfgFunc = f;
      cfgAddr = a;
      cfgRd = 1'h1;
      cyc(1);
      check("read ack", cfgRdAck, 16'h0001);
      check(name, cfgRData, exp);
      cfgRd = 1'h0;
      cfgFunc = 3'h0;
      cyc(1);
   endtask

   task automatic complete_run;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic reg_decode;
      rdchk("enable reset", 8'haa, 16'h0000);
      rdchk("output reset", 8'hae, 16'h0000);
      wr(8'haa, 16'hffff);
      rdchk("enable mask", 8'haa, 16'hc91f);
      wr(8'haa, 16'h0000, 3'h1);
      rdchk("enable other func", 8'haa, 16'hc91f);
      rdchk("read other func", 8'haa, 16'h0000, 3'h1);
      wr(8'hab, 16'h0000, 3'h0, 2'h1);
      rdchk("enable low byte", 8'haa, 16'hc900);
      rdchk("undecoded read", 8'hb0, 16'h0000);
      wr(8'haa, 16'h0000);
   endtask

   task automatic pin_io;
      boardLevel = 5'h0a;
      wr(8'hae, 16'hfff5);
      check("pin drive", multiPinOut, 16'h0015);
      rdchk("output not pin", 8'hae, 16'h0015);
      rdchk("input levels", 8'hac, 16'h000a);
      pinIsOutput = 5'h1f;
      cyc(4);
      check("pin enable", multiPinOe, 16'h001f);
      rdchk("input sees drive", 8'hac, 16'h0015);
      pinIsOutput = 5'h00;
      boardLevel = 5'h00;
      cyc(4);
      wr(8'ha8, 16'hffff);
   endtask

   task automatic event_src(input int k);
      logic [15:0] b;
      b = 16'h0001 << bitPos[k];
      case (k)
         0: video0 = ~video0;
         1: video1 = ~video1;
         2: powerChange = 1'h1;
         3: progVoltChange = 1'h1;
         default: boardLevel[8-k] = ~boardLevel[8-k];
      endcase
      cyc(1);
      powerChange = 1'h0;
      progVoltChange = 1'h0;
      cyc(5);
      check("event gated", eventLine, 16'h0001);
      rdchk("status set", 8'ha8, b);
      wr(8'haa, b);
      cyc(1);
      check("armed", eventLine, 16'h0000);
      cyc(6);
      check("event held", eventLine, 16'h0000);
      wr(8'ha8, b);
      cyc(1);
      check("event released", eventLine, 16'h0001);
      rdchk("status clear", 8'ha8, 16'h0000);
      wr(8'haa, 16'h0000);
   endtask

   task automatic pin_not_input;
      pinIsInput = 5'h0f;
      boardLevel[4] = ~boardLevel[4];
      cyc(6);
      rdchk("unconfigured pin", 8'ha8, 16'h0000);
      pinIsInput = 5'h1f;
   endtask

   task automatic set_beats_clear;
      cfgFunc = 3'h0;
      cfgAddr = 8'ha8;
      cfgWData = 16'h0100;
      cfgByteEn = 2'h3;
      cfgWr = 1'h1;
      progVoltChange = 1'h1;
      cyc(1);
      cfgWr = 1'h0;
      progVoltChange = 1'h0;
      cyc(1);
      rdchk("set beats clear", 8'ha8, 16'h0100);
      wr(8'ha8, 16'h0100);
      rdchk("late clear", 8'ha8, 16'h0000);
      wr(8'haa, 16'h8000);
      video0 = ~video0;
      cyc(2);
      check("live video edge", eventLine, 16'h0000);
      wr(8'ha8, 16'h8000);
      wr(8'haa, 16'h0000);
      check("live edge cleared", eventLine, 16'h0001);
   endtask

   task automatic routing;
      eventPinRouted = 1'h0;
      wr(8'haa, 16'h0800);
      powerChange = 1'h1;
      cyc(1);
      powerChange = 1'h0;
      cyc(3);
      check("event pin off", generalEventOe, 16'h0000);
      check("line idle", eventLine, 16'h0001);
      eventPinRouted = 1'h1;
      cyc(1);
      check("line routed", eventLine, 16'h0000);
      wr(8'ha8, 16'h0800);
   endtask

   initial begin
      cyc(12);
      rst = 1'h0;
      cyc(1);
      wr(8'ha8, 16'hffff);
      reg_decode();
      pin_io();
      for (int k = 0; k < 9; k++) begin
         event_src(k);
      end
      pin_not_input();
      set_beats_clear();
      routing();
      complete_run();
   end

   // whole run is well under 1000 cycles; allow about 2000
   initial begin
      #50000;
      n_errors++;
      complete_run();
   end
endmodule
